// ==== hw/lssa_meas_core.sv ====
// Measurement timer and count scaling of the light sensor.
`timescale 1ns/100ps
module lssa_meas_core
  import lssa_pkg::*;
#(
  parameter int unsigned HIRES_UNIT = HIRES_UNIT_CYCLES,
  parameter int unsigned LORES_UNIT = LORES_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] lightLevel,
  lssa_meas_if.core mi
);
  logic busy_reg;
  logic [16:0] unitCnt_reg;
  logic [7:0] mtCnt_reg;
  logic [7:0] mt_reg;
  lssa_kind_t kind_reg;
  logic done_reg;
  logic [15:0] count_reg;
  logic [16:0] unitLast;
  logic [7:0] mtLast;

  // Scales the raw level by time value, resolution and nominal divisor.
  function automatic logic [15:0] lssa_scale(input logic [15:0] lvl, input logic [7:0] mt, input lssa_kind_t k);
    logic [24:0] num;
    logic [24:0] q;
    num = {9'h000, lvl} * {17'h00000, mt};
    if (k == KIND_HALF)
    begin
      num = num << 1;
    end
    q = num / ((k == KIND_FOUR) ? DIV_FOUR_LUX : DIV_NOMINAL);
    return (q > 25'h000ffff) ? 16'hffff : q[15:0];
  endfunction : lssa_scale

  // The integration lasts time value units, each a fixed fraction of the nominal time.
  assign unitLast = (kind_reg == KIND_FOUR) ? 17'(LORES_UNIT - 1) : 17'(HIRES_UNIT - 1); // [RL4] [RL17]
  assign mtLast = (mt_reg == 8'h00) ? 8'h00 : mt_reg - 8'h01;

  always_ff @(posedge clk)
  begin
    if (rst || mi.abort)
    begin
      busy_reg <= 1'b0;
      unitCnt_reg <= 17'h00000;
      mtCnt_reg <= 8'h00;
    end
    else if (mi.start)
    begin
      busy_reg <= 1'b1;
      unitCnt_reg <= 17'h00000;
      mtCnt_reg <= 8'h00;
    end
    else if (busy_reg)
    begin
      if (unitCnt_reg == unitLast)
      begin
        unitCnt_reg <= 17'h00000;
        mtCnt_reg <= mtCnt_reg + 8'h01;
        if (mtCnt_reg == mtLast)
        begin
          busy_reg <= 1'b0; // [RL9]
        end
      end
      else
      begin
        unitCnt_reg <= unitCnt_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mt_reg <= MT_RESET;
      kind_reg <= KIND_ONE;
    end
    else if (mi.start)
    begin
      mt_reg <= mi.timeValue; // [RL9]
      kind_reg <= mi.kind;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || mi.abort)
    begin
      done_reg <= 1'b0;
      count_reg <= RESULT_RESET;
    end
    else
    begin
      done_reg <= busy_reg && !mi.start && unitCnt_reg == unitLast && mtCnt_reg == mtLast;
      if (busy_reg && unitCnt_reg == unitLast && mtCnt_reg == mtLast)
      begin
        count_reg <= lssa_scale(lightLevel, mt_reg, kind_reg); // [RL10] [RL11]
      end
    end
  end

  assign mi.done = done_reg;
  assign mi.count = count_reg;
endmodule : lssa_meas_core

// ==== hw/lssa_meas_if.sv ====
// Interface between the bus and mode logic and the measurement core.
`timescale 1ns/100ps
interface lssa_meas_if;
  import lssa_pkg::*;
  logic start;
  logic abort;
  lssa_kind_t kind;
  logic [7:0] timeValue;
  logic done;
  logic [15:0] count;
  modport ctrl (output start, output abort, output kind, output timeValue, input done, input count);
  modport core (input start, input abort, input kind, input timeValue, output done, output count);
endinterface : lssa_meas_if

// ==== hw/lssa_pkg.sv ====
// Package with constants and types of the light sensor serial access block.
package lssa_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned HIRES_TIME_US = 120000;
  localparam int unsigned LORES_TIME_US = 16000;
  localparam int unsigned MT_NOMINAL = 69;
  localparam int unsigned HIRES_UNIT_CYCLES = (CLK_HZ / 1000000) * HIRES_TIME_US / MT_NOMINAL;
  localparam int unsigned LORES_UNIT_CYCLES = (CLK_HZ / 1000000) * LORES_TIME_US / MT_NOMINAL;
  localparam logic [24:0] DIV_NOMINAL = 25'h0000045;
  localparam logic [24:0] DIV_FOUR_LUX = 25'h0000114;
  localparam logic [7:0] MT_RESET = 8'h45;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h5c;
  localparam logic [6:0] ADDR_PIN_LOW = 7'h23;
  localparam logic [7:0] OP_POWER_DOWN = 8'h00;
  localparam logic [7:0] OP_POWER_ON = 8'h01;
  localparam logic [7:0] OP_CLEAR = 8'h07;
  localparam logic [7:0] OP_CONT_ONE = 8'h10;
  localparam logic [7:0] OP_CONT_HALF = 8'h11;
  localparam logic [7:0] OP_CONT_FOUR = 8'h13;
  localparam logic [7:0] OP_ONCE_ONE = 8'h20;
  localparam logic [7:0] OP_ONCE_HALF = 8'h21;
  localparam logic [7:0] OP_ONCE_FOUR = 8'h23;
  localparam logic [4:0] OP_MT_HIGH_PREFIX = 5'h08;
  localparam logic [2:0] OP_MT_LOW_PREFIX = 3'h3;
  localparam int unsigned MT_HIGH_LSB = 5;

  typedef enum logic [1:0] {
    MODE_DOWN = 2'b00,
    MODE_ON = 2'b01,
    MODE_MEAS = 2'b10
  } lssa_mode_t;

  typedef enum logic [1:0] {
    KIND_ONE = 2'b00,
    KIND_HALF = 2'b01,
    KIND_FOUR = 2'b10
  } lssa_kind_t;
endpackage : lssa_pkg

// ==== hw/lssa_top.sv ====
// Two-wire slave, opcode decoding and mode control of the light sensor.
//
// Behaviour
// RL1: Address 1011100 with select high, else 0100011.
// RL2: One opcode per write; stop before the next.
// RL3: Read returns count high byte first, MSB first.
// RL4: Time register scales integration time proportionally.
// RL5: Time register resets to 69.
// RL6: Master programs time register within 31 to 254.
// RL7: Opcode 01000_xxx loads time bits 7..5.
// RL8: Opcode 011_xxxxx loads time bits 4..0.
// RL9: Later measurements integrate over the scaled time.
// RL10: Count weight follows 69 over time value.
// RL11: Half-lux mode honours the time register.
// RL12: Opcode 0x11 starts continuous half-lux measuring.
// RL13: Opcode 0x21 measures once, then powers down.
// RL14: Master waits for the first continuous result.
// RL15: Low reset pin clears registers, holds power-down.
// RL16: Opcode 0x07 clears result unless powered down.
// RL17: Opcodes 0x13 and 0x23 run four-lux measurements.
// RL18: Master resends opcode after a one-shot result.
// RL19: Unknown opcodes change nothing.
// RL20: Result reads zero before any measurement.
`timescale 1ns/100ps
module lssa_top
  import lssa_pkg::*;
#(
  parameter int unsigned HIRES_UNIT = HIRES_UNIT_CYCLES,
  parameter int unsigned LORES_UNIT = LORES_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSel,
  input wire logic resetPinN,
  input wire logic [15:0] lightLevel,
  output logic poweredUp,
  output logic measuring
);
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_WRITE_ACK = 3'b100,
    BUS_READ = 3'b101,
    BUS_READ_ACK = 3'b110
  } lssa_bus_t;

  lssa_meas_if mi();

  logic sclMeta_reg, sclSync_reg, sclPrev_reg;
  logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;
  logic addrMeta_reg, addrSync_reg;
  logic resetMeta_reg, resetSync_reg;
  logic [15:0] lightMeta_reg, lightSync_reg;
  logic coreRst;
  logic sclRise, sclFall, busStart, busStop;
  lssa_bus_t bus_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] txShift_reg;
  logic [15:0] readShadow_reg;
  logic lowByte_reg;
  logic gotOp_reg;
  logic masterAck_reg;
  logic sdaOe_reg;
  logic opValid_reg;
  logic [7:0] opByte_reg;
  logic [6:0] ownAddr;
  lssa_mode_t mode_reg;
  logic continuous_reg;
  lssa_kind_t kind_reg;
  logic [7:0] timeValue_reg;
  logic [15:0] result_reg;
  logic startMeas;
  logic abortMeas;

  // Pins cross into the clock domain through two flip-flops each.
  always_ff @(posedge clk)
  begin
    sclMeta_reg <= sclIn;
    sclSync_reg <= sclMeta_reg;
    sclPrev_reg <= sclSync_reg;
    sdaMeta_reg <= sdaIn;
    sdaSync_reg <= sdaMeta_reg;
    sdaPrev_reg <= sdaSync_reg;
    addrMeta_reg <= addrSel;
    addrSync_reg <= addrMeta_reg;
    resetMeta_reg <= resetPinN;
    resetSync_reg <= resetMeta_reg;
    lightMeta_reg <= lightLevel;
    lightSync_reg <= lightMeta_reg;
  end

  assign coreRst = rst || !resetSync_reg; // [RL15]
  assign sclRise = sclSync_reg && !sclPrev_reg;
  assign sclFall = !sclSync_reg && sclPrev_reg;
  assign busStart = sclSync_reg && sclPrev_reg && sdaPrev_reg && !sdaSync_reg;
  assign busStop = sclSync_reg && sclPrev_reg && !sdaPrev_reg && sdaSync_reg;
  assign ownAddr = addrSync_reg ? ADDR_PIN_HIGH : ADDR_PIN_LOW; // [RL1]

  // Bus sequencing, bit counting and acknowledge driving.
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      bus_reg <= BUS_IDLE;
      bitCnt_reg <= 4'h0;
      rxShift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      readShadow_reg <= RESULT_RESET;
      lowByte_reg <= 1'b0;
      gotOp_reg <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end
    else if (busStart)
    begin
      bus_reg <= BUS_ADDR;
      bitCnt_reg <= 4'h0;
      gotOp_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end
    else if (busStop)
    begin
      bus_reg <= BUS_IDLE;
      gotOp_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
    end
    else if (sclRise)
    begin
      unique case (bus_reg)
        BUS_ADDR, BUS_WRITE:
        begin
          rxShift_reg <= {rxShift_reg[6:0], sdaSync_reg};
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        BUS_READ:
        begin
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        BUS_READ_ACK:
        begin
          masterAck_reg <= !sdaSync_reg;
        end
        BUS_IDLE, BUS_ADDR_ACK, BUS_WRITE_ACK:
        begin
        end
      endcase
    end
    else if (sclFall)
    begin
      unique case (bus_reg)
        BUS_ADDR:
        begin
          if (bitCnt_reg == 4'h8)
          begin
            if (rxShift_reg[7:1] == ownAddr) // [RL1]
            begin
              bus_reg <= BUS_ADDR_ACK;
              sdaOe_reg <= 1'b1;
              readShadow_reg <= result_reg;
            end
            else
            begin
              bus_reg <= BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK:
        begin
          bitCnt_reg <= 4'h0;
          lowByte_reg <= 1'b0;
          if (rxShift_reg[0])
          begin
            bus_reg <= BUS_READ;
            txShift_reg <= readShadow_reg[15:8]; // [RL3]
            sdaOe_reg <= !readShadow_reg[15];
          end
          else
          begin
            bus_reg <= BUS_WRITE;
            sdaOe_reg <= 1'b0;
          end
        end
        BUS_WRITE:
        begin
          if (bitCnt_reg == 4'h8)
          begin
            if (!gotOp_reg)
            begin
              bus_reg <= BUS_WRITE_ACK;
              sdaOe_reg <= 1'b1;
              gotOp_reg <= 1'b1;
            end
            else
            begin
              bus_reg <= BUS_IDLE; // [RL2]
            end
          end
        end
        BUS_WRITE_ACK:
        begin
          bus_reg <= BUS_IDLE; // [RL2]
          sdaOe_reg <= 1'b0;
        end
        BUS_READ:
        begin
          if (bitCnt_reg == 4'h8)
          begin
            bus_reg <= BUS_READ_ACK;
            sdaOe_reg <= 1'b0;
          end
          else
          begin
            txShift_reg <= {txShift_reg[6:0], 1'b0};
            sdaOe_reg <= !txShift_reg[6]; // [RL3]
          end
        end
        BUS_READ_ACK:
        begin
          bitCnt_reg <= 4'h0;
          if (masterAck_reg && !lowByte_reg)
          begin
            bus_reg <= BUS_READ;
            lowByte_reg <= 1'b1;
            txShift_reg <= readShadow_reg[7:0]; // [RL3]
            sdaOe_reg <= !readShadow_reg[7];
          end
          else
          begin
            bus_reg <= BUS_IDLE;
          end
        end
        BUS_IDLE:
        begin
        end
      endcase
    end
  end

  // A one-cycle opcode strobe leaves the bus at the end of the accepted byte.
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      opValid_reg <= 1'b0;
      opByte_reg <= 8'h00;
    end
    else
    begin
      opValid_reg <= sclFall && !busStart && !busStop && bus_reg == BUS_WRITE && bitCnt_reg == 4'h8 && !gotOp_reg;
      opByte_reg <= rxShift_reg;
    end
  end

  // Time register updates from the split loading opcodes.
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      timeValue_reg <= MT_RESET; // [RL5]
    end
    else if (opValid_reg && opByte_reg[7:3] == OP_MT_HIGH_PREFIX)
    begin
      timeValue_reg[7:MT_HIGH_LSB] <= opByte_reg[2:0]; // [RL7]
    end
    else if (opValid_reg && opByte_reg[7:5] == OP_MT_LOW_PREFIX)
    begin
      timeValue_reg[MT_HIGH_LSB-1:0] <= opByte_reg[4:0]; // [RL8]
    end
  end

  // Mode control: power states, measurement kind and repetition.
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      mode_reg <= MODE_DOWN; // [RL15]
      continuous_reg <= 1'b0;
      kind_reg <= KIND_ONE;
    end
    else if (opValid_reg)
    begin
      unique case (opByte_reg)
        OP_POWER_DOWN: mode_reg <= MODE_DOWN;
        OP_POWER_ON: mode_reg <= MODE_ON;
        OP_CONT_ONE, OP_CONT_HALF, OP_CONT_FOUR, OP_ONCE_ONE, OP_ONCE_HALF, OP_ONCE_FOUR:
        begin
          mode_reg <= MODE_MEAS;
          continuous_reg <= !opByte_reg[5]; // [RL12] [RL13]
          kind_reg <= opByte_reg[1] ? KIND_FOUR : (opByte_reg[0] ? KIND_HALF : KIND_ONE); // [RL17]
        end
        default: // [RL19]
        begin
        end
      endcase
    end
    else if (mi.done && !continuous_reg)
    begin
      mode_reg <= MODE_DOWN; // [RL13]
    end
  end

  assign startMeas = opValid_reg && (opByte_reg == OP_CONT_ONE || opByte_reg == OP_CONT_HALF ||
    opByte_reg == OP_CONT_FOUR || opByte_reg == OP_ONCE_ONE || opByte_reg == OP_ONCE_HALF ||
    opByte_reg == OP_ONCE_FOUR);
  assign abortMeas = opValid_reg && (opByte_reg == OP_POWER_DOWN || opByte_reg == OP_POWER_ON);
  assign mi.start = startMeas || (mi.done && continuous_reg && mode_reg == MODE_MEAS); // [RL12]
  assign mi.abort = abortMeas;
  assign mi.kind = startMeas ? (opByte_reg[1] ? KIND_FOUR : (opByte_reg[0] ? KIND_HALF : KIND_ONE)) : kind_reg;
  assign mi.timeValue = timeValue_reg; // [RL9]

  // Result register; unknown opcodes fall through without touching it.
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      result_reg <= RESULT_RESET; // [RL20]
    end
    else if (mi.done)
    begin
      result_reg <= mi.count;
    end
    else if (opValid_reg && opByte_reg == OP_CLEAR && mode_reg != MODE_DOWN)
    begin
      result_reg <= RESULT_RESET; // [RL16] [RL19]
    end
  end

  lssa_meas_core #(
    .HIRES_UNIT(HIRES_UNIT),
    .LORES_UNIT(LORES_UNIT)
  ) u_core (
    .clk(clk),
    .rst(coreRst),
    .lightLevel(lightSync_reg),
    .mi(mi.core)
  );

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign poweredUp = mode_reg != MODE_DOWN;
  assign measuring = mode_reg == MODE_MEAS;
endmodule : lssa_top

// ==== test/lssa_bus_master.sv ====
// Behavioural two-wire bus master driving the sensor's clock and data lines.
`timescale 1ns/100ps
module lssa_bus_master
(
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaM
);
  initial
  begin
    scl = 1'b1;
    sdaM = 1'b1;
  end
  task automatic pins(input logic c, input logic d, input int n);
    scl = c;
    sdaM = d;
    repeat (n) @(negedge clk);
  endtask : pins
  // The clock rests high outside frames; data moves while the clock is low, except at the start and stop edges.
  task automatic start();
    pins(scl, sdaM, 2);
    pins(scl, 1'b1, 2);
    pins(1'b1, 1'b1, 4);
    pins(1'b1, 1'b0, 4);
    pins(1'b0, 1'b0, 2);
  endtask : start
  task automatic stop();
    pins(scl, sdaM, 2);
    pins(1'b0, 1'b0, 2);
    pins(1'b1, 1'b0, 4);
    pins(1'b1, 1'b1, 4);
  endtask : stop
  task automatic xb(input logic b, output logic r);
    pins(1'b0, b, 4);
    pins(1'b1, b, 1);
    r = sdaLine;
    pins(1'b1, b, 1);
    pins(1'b0, b, 2);
  endtask : xb
  // A byte goes MSB first, then the acknowledge bit; a released line reads as refused.
  task automatic xbyte(input logic [7:0] d, input logic ackIn, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      xb(d[i], r[i]);
    xb(ackIn, a);
    ack = !a;
  endtask : xbyte
endmodule : lssa_bus_master

// ==== test/lssa_top_checker.sv ====
// Concurrent checks on the pins of the light sensor serial access block.
`timescale 1ns/100ps
module lssa_top_checker
  import lssa_pkg::*;
#(
  parameter int unsigned HIRES_UNIT = HIRES_UNIT_CYCLES,
  parameter int unsigned LORES_UNIT = LORES_UNIT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic addrSel,
  input wire logic resetPinN,
  input wire logic [15:0] lightLevel,
  input wire logic poweredUp,
  input wire logic measuring
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [3:0] sinceFall;
  // Counts cycles since the bus clock last fell, saturating at the top.
  always_ff @(posedge clk)
  begin
    if (rst)
      sinceFall <= 4'hf;
    else if ($fell(sclIn))
      sinceFall <= 4'h0;
    else if (sinceFall != 4'hf)
      sinceFall <= sinceFall + 4'h1;
  end
  sequence pinLow;
    !resetPinN [*3];
  endsequence
  drain_low_a: assert property (sdaOut == 1'b0) else $error("data pin driven high");
  pin_reset_a: assert property (pinLow |-> ##2 (!poweredUp && !measuring && !sdaOe))
    else $error("reset pin did not clear state");
  meas_power_a: assert property ($fell(measuring) |-> !poweredUp || sinceFall <= 4'h8)
    else $error("measurement ended without power-down");
  oe_high_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data drive moved while clock high");
  oe_fall_a: assert property ($changed(sdaOe) |-> sinceFall <= 4'h8)
    else $error("data drive moved away from clock fall");
  meas_start_a: assert property ($rose(measuring) |-> sinceFall <= 4'h8)
    else $error("measurement began outside an opcode");
  power_up_a: assert property ($rose(poweredUp) |-> sinceFall <= 4'h8)
    else $error("power came up outside an opcode");
  start_free_a: assert property (sclIn && $fell(sdaIn) |-> !sdaOe)
    else $error("data pulled low while clock high");
endmodule : lssa_top_checker
bind lssa_top lssa_top_checker #(.HIRES_UNIT(HIRES_UNIT), .LORES_UNIT(LORES_UNIT)) chk (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .addrSel(addrSel), .resetPinN(resetPinN), .lightLevel(lightLevel),
  .poweredUp(poweredUp), .measuring(measuring));

// ==== test/tb_top.sv ====
// Self-checking bench of the light sensor serial access block.
`timescale 1ns/100ps
module tb_top;
  import lssa_pkg::*;
  localparam int unsigned HU = 20;
  localparam int unsigned LU = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic addrSel = 1'b0;
  logic resetPinN = 1'b0;
  logic [15:0] lightLevel = 16'h0000;
  logic scl, sdaM, sdaOut, sdaOe, poweredUp, measuring, ak;
  logic [7:0] rb;
  logic [6:0] adr = ADDR_PIN_LOW;
  logic [15:0] res = RESULT_RESET;
  logic [7:0] onceOps [$] = '{OP_ONCE_ONE, OP_ONCE_HALF, OP_ONCE_FOUR};
  logic [7:0] contOps [$] = '{OP_CONT_ONE, OP_CONT_HALF, OP_CONT_FOUR};
  logic [7:0] badOps [$] = '{8'h02, 8'h55, 8'hff};
  int bad_count = 0, tests_run = 0, cyc = 0, curRun = 0, lastRun = 0, tv = 69;
  wire logic sda = (sdaOe ? sdaOut : 1'b1) & sdaM;
  always #12.5 clk = ~clk;
  lssa_bus_master m (.clk(clk), .sdaLine(sda), .scl(scl), .sdaM(sdaM));
  lssa_top #(.HIRES_UNIT(HU), .LORES_UNIT(LU)) dut (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSel(addrSel), .resetPinN(resetPinN), .lightLevel(lightLevel),
    .poweredUp(poweredUp), .measuring(measuring));
  // Tracks the length of the last measurement and cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    curRun <= measuring === 1'b1 ? curRun + 1 : 0;
    if (measuring !== 1'b1 && curRun != 0)
      lastRun <= curRun;
    if (cyc == 90000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp16
  task automatic cmp1(input logic g, input logic e);
    cmp16({15'h0, g}, {15'h0, e});
  endtask : cmp1
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  function automatic int per(input int k);
    return tv * (k == 2 ? LU : HU);
  endfunction : per
  function automatic logic [15:0] cnt(input int k, input int l);
    int v;
    v = k == 0 ? l * tv / 69 : (k == 1 ? l * 2 * tv / 69 : l * tv / 276);
    return v > 65535 ? 16'hffff : v[15:0];
  endfunction : cnt
  task automatic wr(input logic [7:0] op);
    m.start();
    m.xbyte({adr, 1'b0}, 1'b1, rb, ak);
    cmp1(ak, 1'b1);
    m.xbyte(op, 1'b1, rb, ak);
    cmp1(ak, 1'b1);
    m.stop();
  endtask : wr
  task automatic rd(input logic [15:0] e);
    logic [15:0] d;
    m.start();
    m.xbyte({adr, 1'b1}, 1'b1, d[15:8], ak);
    cmp1(ak, 1'b1);
    m.xbyte(8'hff, 1'b0, d[15:8], ak);
    m.xbyte(8'hff, 1'b1, d[7:0], ak);
    m.stop();
    cmp16(d, e);
  endtask : rd
  task automatic setTv(input logic [7:0] t);
    wr({OP_MT_HIGH_PREFIX, t[7:5]});
    wr({OP_MT_LOW_PREFIX, t[4:0]});
    tv = t;
  endtask : setTv
  task automatic once(input logic [7:0] op, input int k);
    lightLevel = 16'($urandom);
    wr(op);
    for (int i = 0; i < 9000 && measuring !== 1'b0; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    cmp1(lastRun >= per(k) - 4 && lastRun <= per(k) + 4, 1'b1);
    cmp1(poweredUp, 1'b0);
    res = cnt(k, lightLevel);
    rd(res);
  endtask : once
  initial
  begin
    void'($urandom(66));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (31) @(negedge clk);
    resetPinN = 1'b1;
    repeat (5) @(negedge clk);
    cmp1(poweredUp, 1'b0);
    rd(RESULT_RESET);
    m.start();
    m.xbyte({ADDR_PIN_HIGH, 1'b0}, 1'b1, rb, ak);
    m.stop();
    cmp1(ak, 1'b0);
    once(OP_ONCE_ONE, 0);
    for (int i = 0; i < 3; i++)
    begin
      setTv(8'(31 + $urandom % 224));
      wr(badOps[i]);
      rd(res);
      cmp1(poweredUp, 1'b0);
      once(onceOps[i], i);
      wr(OP_CLEAR);
      rd(res);
    end
    addrSel = 1'b1;
    adr = ADDR_PIN_HIGH;
    setTv(8'd31);
    for (int i = 0; i < 3; i++)
    begin
      lightLevel = 16'($urandom);
      wr(contOps[i]);
      repeat (per(i) * 3 / 2) @(negedge clk);
      rd(cnt(i, lightLevel));
      lightLevel = 16'($urandom);
      repeat (per(i) * 2 + 8) @(negedge clk);
      res = cnt(i, lightLevel);
      rd(res);
      cmp1(measuring, 1'b1);
    end
    wr(OP_POWER_DOWN);
    cmp1(poweredUp, 1'b0);
    wr(OP_CLEAR);
    rd(res);
    wr(OP_POWER_ON);
    cmp1(poweredUp, 1'b1);
    wr(OP_CLEAR);
    rd(RESULT_RESET);
    m.start();
    m.xbyte({adr, 1'b0}, 1'b1, rb, ak);
    m.xbyte(OP_POWER_DOWN, 1'b1, rb, ak);
    m.xbyte(OP_POWER_ON, 1'b1, rb, ak);
    m.stop();
    cmp1(ak, 1'b0);
    cmp1(poweredUp, 1'b0);
    wr(OP_CONT_HALF);
    repeat (per(1) + 50) @(negedge clk);
    resetPinN = 1'b0;
    repeat (40) @(negedge clk);
    resetPinN = 1'b1;
    repeat (5) @(negedge clk);
    cmp1(measuring, 1'b0);
    rd(RESULT_RESET);
    tv = 69;
    once(OP_ONCE_HALF, 1);
    finish_test();
  end
endmodule : tb_top
